//--- verilog/mct_pkg.sv
// Constants and types of the card command decoder
package mct_pkg;
  // Register byte offsets
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_TRIP_CLR = 4'h8;
  // Reset values
  localparam logic [15:0] CMD_RST = 16'h0000;
  // Whole command codes, and the divisor one thousand
  localparam logic [15:0] CODE_BOOT = 16'h07d1;
  localparam logic [15:0] CODE_FORMAT = 16'h270f;
  localparam logic [15:0] CODE_WARN_CLR = 16'h2553;
  localparam logic [15:0] CODE_WARN_SET = 16'h25c2;
  localparam logic [15:0] CODE_WP_CLR = 16'h2631;
  localparam logic [15:0] CODE_WP_SET = 16'h26a0;
  localparam logic [15:0] K_THOUSAND = 16'h03e8;
  // Prefixes, the code divided by one thousand; then the block field limits
  localparam logic [6:0] PRE_PSAVE = 7'h04;
  localparam logic [6:0] PRE_GSAVE = 7'h05;
  localparam logic [6:0] PRE_LOAD = 7'h06;
  localparam logic [6:0] PRE_ERASE = 7'h07;
  localparam logic [6:0] PRE_CMP = 7'h08;
  localparam logic [6:0] PRE_OSAVE1 = 7'h0f;
  localparam logic [6:0] PRE_OSAVE2 = 7'h10;
  localparam logic [6:0] PRE_OSAVE3 = 7'h11;
  localparam logic [6:0] PRE_OLOAD1 = 7'h12;
  localparam logic [6:0] PRE_OLOAD2 = 7'h13;
  localparam logic [6:0] PRE_OLOAD3 = 7'h14;
  localparam logic [6:0] PRE_OSAVE4 = 7'h15;
  localparam logic [6:0] PRE_OLOAD4 = 7'h16;
  localparam logic [6:0] PRE_BACKUP = 7'h28;
  localparam logic [6:0] PRE_RESTORE = 7'h3c;
  localparam logic [9:0] BLK_MIN = 10'h001;
  localparam logic [9:0] BLK_MAX = 10'h3e7;
  // Status bit positions; trips sit in [5:3]
  localparam int ST_BUSY = 0;
  localparam int ST_WP = 1;
  localparam int ST_WARN = 2;
  localparam int ST_TRIP = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    OP_NONE, OP_PSAVE, OP_GSAVE, OP_LOAD, OP_ERASE, OP_CMP,
    OP_FORMAT, OP_OSAVE, OP_OLOAD, OP_BACKUP, OP_RESTORE
  } mct_op_type;
  typedef enum logic [1:0] {S_IDLE = 2'b01, S_BUSY = 2'b10} mct_state_type;
endpackage

//--- verilog/mct_cmd_decoder.sv
// Card command decoder with AXI4-Lite register access
//
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - Operations are codes written to command_parameter, started by drive reset.
// - Code 2001 saves all parameters into block 1, marked bootable.
// - Parameter-save code writes drive and option parameters into block yyy.
// - Program-save code copies the onboard user program into block yyy.
// - Load code loads parameters or program from block yyy by content.
// - Erase removes block yyy only; 9999 erases and reformats the card.
// - Compare clears command_parameter on match, raises compare trip on mismatch.
// - 9666 sets, 9555 clears the warning suppression flag.
// - 9888 sets, 9777 clears the write-protect flag.
// - With write-protect set only prefix 6 load codes and 9777 take effect; option loads do not.
// - SD only: slots 1..4 save option program, prefixes 15,16,17,21.
// - SD only: slots 1..4 load option program, prefixes 18,19,20,22.
// - SD backup saves everything, clears the code once all is saved.
// - SD restore keeps the code set until all data is loaded.
// - Block field yyy lies between 001 and 999.
// - Parameter-save blocks hold only differences from last defaults.
// - Non-copyable parameters are excluded from card writes.
// - Card removal during a transfer raises a trip.
// - Write or erase attempt under write-protect raises a trip.
module mct_cmd_decoder
  import mct_pkg::*;
(
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic drive_reset_in,
  input wire logic card_present_in,
  input wire logic card_sd_in,
  input wire logic card_done_in,
  input wire logic card_match_in,
  output logic card_req_out,
  output logic [3:0] card_op_out,
  output logic [9:0] card_block_out,
  output logic [2:0] card_slot_out,
  output logic card_boot_out,
  output logic card_diff_only_out,
  output logic card_skip_nocopy_out,
  output logic wp_flag_out,
  output logic warn_flag_out,
  output logic trip_out,
  input wire logic [3:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [3:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in
);
  // Bus state
  logic aw_got_ff, nxt_aw_got, w_got_ff, nxt_w_got;
  logic [3:0] aw_addr_ff, nxt_aw_addr;
  logic [31:0] wdata_ff, nxt_wdata;
  logic [3:0] wstrb_ff, nxt_wstrb;
  logic awready_ff, nxt_awready, wready_ff, nxt_wready;
  logic bvalid_ff, nxt_bvalid, arready_ff, nxt_arready;
  logic rvalid_ff, nxt_rvalid;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;
  logic wr_cmd, wr_clr;
  // Core state
  mct_state_type state_ff, nxt_state;
  logic [15:0] cmd_ff, nxt_cmd;
  logic wp_ff, nxt_wp, warn_ff, nxt_warn;
  logic [2:0] trip_ff, nxt_trip;
  logic req_ff, nxt_req, boot_ff, nxt_boot;
  logic diff_ff, nxt_diff, nocopy_ff, nxt_nocopy;
  mct_op_type op_ff, nxt_op;
  logic [9:0] blk_ff, nxt_blk;
  logic [2:0] slot_ff, nxt_slot;
  logic tripo_ff, nxt_tripo;
  // Decode
  logic [15:0] quo, rem;
  logic [6:0] pre;
  logic [9:0] blk;
  logic blk_ok;
  mct_op_type dec_op;
  logic [2:0] dec_slot;
  logic dec_wr;
  logic [31:0] status;

  // Division by a constant: a long path, but reset commits are rare
  assign quo = cmd_ff / K_THOUSAND;
  assign rem = cmd_ff % K_THOUSAND;
  assign pre = quo[6:0];
  assign blk = rem[9:0];
  assign blk_ok = (blk >= BLK_MIN) && (blk <= BLK_MAX);
  assign status = {26'h0, trip_ff, warn_ff, wp_ff, req_ff};

  always_comb begin
    dec_op = OP_NONE;
    dec_slot = 3'h0;
    if (cmd_ff == CODE_FORMAT) begin
      dec_op = OP_FORMAT;
    end else if (cmd_ff == CODE_BOOT) begin
      dec_op = OP_PSAVE;
    end else if (blk_ok && quo[15:7] == 9'h000) begin
      case (pre)
        PRE_PSAVE: dec_op = OP_PSAVE;
        PRE_GSAVE: dec_op = OP_GSAVE;
        PRE_LOAD: dec_op = OP_LOAD;
        PRE_ERASE: dec_op = OP_ERASE;
        PRE_CMP: dec_op = OP_CMP;
        default: dec_op = OP_NONE;
      endcase
      if (card_sd_in) begin
        case (pre)
          PRE_OSAVE1, PRE_OSAVE2, PRE_OSAVE3: begin
            dec_op = OP_OSAVE;
            dec_slot = 3'(pre - PRE_OSAVE1 + 7'h01);
          end
          PRE_OSAVE4: begin
            dec_op = OP_OSAVE;
            dec_slot = 3'h4;
          end
          PRE_OLOAD1, PRE_OLOAD2, PRE_OLOAD3: begin
            dec_op = OP_OLOAD;
            dec_slot = 3'(pre - PRE_OLOAD1 + 7'h01);
          end
          PRE_OLOAD4: begin
            dec_op = OP_OLOAD;
            dec_slot = 3'h4;
          end
          PRE_BACKUP: dec_op = OP_BACKUP;
          PRE_RESTORE: dec_op = OP_RESTORE;
          default: ;
        endcase
      end
    end
    dec_wr = (dec_op == OP_PSAVE) || (dec_op == OP_GSAVE) || (dec_op == OP_ERASE)
      || (dec_op == OP_FORMAT) || (dec_op == OP_OSAVE) || (dec_op == OP_BACKUP);
  end

  // Bus: address and data are taken in either order, answered together
  always_comb begin
    nxt_aw_got = aw_got_ff;
    nxt_aw_addr = aw_addr_ff;
    nxt_w_got = w_got_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rresp = rresp_ff;
    nxt_rdata = rdata_ff;
    wr_cmd = 1'b0;
    wr_clr = 1'b0;
    if (s_axi_awvalid_in && awready_ff) begin
      nxt_aw_got = 1'b1;
      nxt_aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && wready_ff) begin
      nxt_w_got = 1'b1;
      nxt_wdata = s_axi_wdata_in;
      nxt_wstrb = s_axi_wstrb_in;
    end
    if (bvalid_ff && s_axi_bready_in) begin
      nxt_bvalid = 1'b0;
    end
    if (aw_got_ff && w_got_ff && !bvalid_ff) begin
      nxt_aw_got = 1'b0;
      nxt_w_got = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = RESP_OKAY;
      if (aw_addr_ff == REG_CMD) begin
        wr_cmd = 1'b1;
      end else if (aw_addr_ff == REG_TRIP_CLR) begin
        wr_clr = 1'b1;
      end else if (aw_addr_ff != REG_STATUS) begin
        nxt_bresp = RESP_SLVERR;
      end
    end
    nxt_awready = !nxt_aw_got && !nxt_bvalid;
    nxt_wready = !nxt_w_got && !nxt_bvalid;
    if (rvalid_ff && s_axi_rready_in) begin
      nxt_rvalid = 1'b0;
    end
    if (s_axi_arvalid_in && arready_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = RESP_OKAY;
      if (s_axi_araddr_in == REG_CMD) begin
        nxt_rdata = {16'h0000, cmd_ff};
      end else if (s_axi_araddr_in == REG_STATUS) begin
        nxt_rdata = status;
      end else if (s_axi_araddr_in == REG_TRIP_CLR) begin
        nxt_rdata = 32'h0000_0000;
      end else begin
        nxt_rdata = 32'h0000_0000;
        nxt_rresp = RESP_SLVERR;
      end
    end
    nxt_arready = !nxt_rvalid;
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      aw_got_ff <= 1'b0;
      aw_addr_ff <= 4'h0;
      w_got_ff <= 1'b0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
    end else begin
      aw_got_ff <= nxt_aw_got;
      aw_addr_ff <= nxt_aw_addr;
      w_got_ff <= nxt_w_got;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
    end
  end

  // Core: commit on drive reset, then hold the card request until done or card removal
  always_comb begin
    nxt_state = state_ff;
    nxt_cmd = cmd_ff;
    nxt_wp = wp_ff;
    nxt_warn = warn_ff;
    nxt_req = req_ff;
    nxt_op = op_ff;
    nxt_blk = blk_ff;
    nxt_slot = slot_ff;
    nxt_boot = boot_ff;
    nxt_diff = diff_ff;
    nxt_nocopy = nocopy_ff;
    nxt_trip = wr_clr ? (trip_ff & ~wdata_ff[ST_TRIP+2:ST_TRIP]) : trip_ff;
    case (state_ff)
      S_IDLE: begin
        if (drive_reset_in) begin
          if (wp_ff && cmd_ff == CODE_WP_CLR) begin
            nxt_wp = 1'b0;
            nxt_cmd = CMD_RST;
          end else if (wp_ff && dec_op != OP_LOAD) begin
            nxt_trip[1] = dec_wr;
            nxt_trip[1] = nxt_trip[1] | trip_ff[1] & ~(wr_clr & wdata_ff[ST_TRIP+1]);
          end else if (cmd_ff == CODE_WARN_SET) begin
            nxt_warn = 1'b1;
            nxt_cmd = CMD_RST;
          end else if (cmd_ff == CODE_WARN_CLR) begin
            nxt_warn = 1'b0;
            nxt_cmd = CMD_RST;
          end else if (cmd_ff == CODE_WP_SET) begin
            nxt_wp = 1'b1;
            nxt_cmd = CMD_RST;
          end else if (cmd_ff == CODE_WP_CLR) begin
            nxt_cmd = CMD_RST;
          end else if (dec_op != OP_NONE) begin
            nxt_state = S_BUSY;
            nxt_req = 1'b1;
            nxt_op = dec_op;
            nxt_blk = (dec_op == OP_FORMAT) ? 10'h000 : blk;
            nxt_slot = dec_slot;
            nxt_boot = (cmd_ff == CODE_BOOT);
            nxt_diff = (dec_op == OP_PSAVE) && (cmd_ff != CODE_BOOT);
            nxt_nocopy = dec_wr;
          end
        end
      end
      S_BUSY: begin
        if (!card_present_in) begin
          nxt_trip[2] = 1'b1;
          nxt_req = 1'b0;
          nxt_state = S_IDLE;
        end else if (card_done_in) begin
          nxt_req = 1'b0;
          nxt_state = S_IDLE;
          if (op_ff == OP_CMP && !card_match_in) begin
            nxt_trip[0] = 1'b1;
          end else begin
            nxt_cmd = CMD_RST;
          end
        end
      end
      default: nxt_state = S_IDLE;
    endcase
    if (wr_cmd) begin
      if (wstrb_ff[0]) nxt_cmd[7:0] = wdata_ff[7:0];
      if (wstrb_ff[1]) nxt_cmd[15:8] = wdata_ff[15:8];
    end
    nxt_tripo = |nxt_trip;
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      state_ff <= S_IDLE;
      cmd_ff <= CMD_RST;
      wp_ff <= 1'b0;
      warn_ff <= 1'b0;
      trip_ff <= 3'h0;
      req_ff <= 1'b0;
      op_ff <= OP_NONE;
      blk_ff <= 10'h000;
      slot_ff <= 3'h0;
      boot_ff <= 1'b0;
      diff_ff <= 1'b0;
      nocopy_ff <= 1'b0;
      tripo_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cmd_ff <= nxt_cmd;
      wp_ff <= nxt_wp;
      warn_ff <= nxt_warn;
      trip_ff <= nxt_trip;
      req_ff <= nxt_req;
      op_ff <= nxt_op;
      blk_ff <= nxt_blk;
      slot_ff <= nxt_slot;
      boot_ff <= nxt_boot;
      diff_ff <= nxt_diff;
      nocopy_ff <= nxt_nocopy;
      tripo_ff <= nxt_tripo;
    end
  end

  assign card_req_out = req_ff;
  assign card_op_out = op_ff;
  assign card_block_out = blk_ff;
  assign card_slot_out = slot_ff;
  assign card_boot_out = boot_ff;
  assign card_diff_only_out = diff_ff;
  assign card_skip_nocopy_out = nocopy_ff;
  assign wp_flag_out = wp_ff;
  assign warn_flag_out = warn_ff;
  assign trip_out = tripo_ff;
  assign s_axi_awready_out = awready_ff;
  assign s_axi_wready_out = wready_ff;
  assign s_axi_bvalid_out = bvalid_ff;
  assign s_axi_bresp_out = bresp_ff;
  assign s_axi_arready_out = arready_ff;
  assign s_axi_rvalid_out = rvalid_ff;
  assign s_axi_rresp_out = rresp_ff;
  assign s_axi_rdata_out = rdata_ff;

  default clocking @(posedge clock_in); endclocking
  default disable iff (srst_in);
  sequence s_commit;
    state_ff == S_IDLE && drive_reset_in && !wr_cmd;
  endsequence
  sequence s_end_ok;
    req_ff && card_present_in && card_done_in && !wr_cmd;
  endsequence
  AST_START_NEEDS_RESET: assert property ($rose(req_ff) |-> $past(drive_reset_in))
    else $error("card request without drive reset");
  AST_BOOT_BLOCK: assert property ($rose(req_ff) && boot_ff |-> blk_ff == 10'h001
    && op_ff == OP_PSAVE) else $error("boot save not to block 1");
  AST_DIFF_ONLY: assert property ($rose(req_ff) |-> diff_ff == (op_ff == OP_PSAVE
    && !boot_ff)) else $error("difference flag wrong");
  AST_WP_LOAD_ONLY: assert property ($rose(req_ff) && wp_ff |-> op_ff == OP_LOAD)
    else $error("operation started under write protect");
  AST_CMP_FAIL: assert property (s_end_ok ##0 (op_ff == OP_CMP && !card_match_in)
    |=> trip_ff[0] && cmd_ff == $past(cmd_ff)) else $error("compare failure lost");
  AST_DONE_CLEARS: assert property (s_end_ok ##0 (op_ff != OP_CMP || card_match_in)
    |=> cmd_ff == CMD_RST && !req_ff) else $error("code not cleared at end");
  AST_WARN_SET: assert property (s_commit ##0 (!wp_ff && cmd_ff == CODE_WARN_SET)
    |=> warn_ff ##1 warn_ff) else $error("warning flag not set");
  AST_WP_SET: assert property (s_commit ##0 (cmd_ff == CODE_WP_SET)
    |=> wp_ff && cmd_ff == (($past(wp_ff)) ? CODE_WP_SET : CMD_RST))
    else $error("write protect set wrong");
  AST_REMOVED: assert property (req_ff && !card_present_in |=> trip_ff[2] && !req_ff)
    else $error("card removal not tripped");
  AST_BLK_RANGE: assert property ($rose(req_ff) && op_ff != OP_FORMAT
    |-> blk_ff >= BLK_MIN && blk_ff <= BLK_MAX) else $error("block out of range");
  AST_SD_ONLY: assert property ($rose(req_ff) && op_ff >= OP_OSAVE
    |-> $past(card_sd_in)) else $error("SD operation on other media");
  AST_WP_TRIP: assert property (s_commit ##0 (wp_ff && dec_wr) |=> trip_ff[1]
    && !req_ff) else $error("write under protect not tripped");
endmodule
`default_nettype wire

//--- test/mct_card_model.sv
// Behavioural model of the removable memory card
`timescale 1ns/100ps
`default_nettype none
module mct_card_model (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic req_in,
  input wire logic [3:0] delay_in,
  input wire logic match_mode_in,
  input wire logic pull_in,
  output logic done_out,
  output logic match_out,
  output logic present_out
);
  logic [3:0] cnt_ff;
  logic fin_ff, done_ff, tog_ff;
  // A pulled card never finishes, so the decoder has to notice the loss itself
  always_ff @(posedge clock_in) begin
    tog_ff <= srst_in ? 1'b0 : ~tog_ff;
    if (srst_in || !req_in) begin
      cnt_ff <= 4'h0;
      fin_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (!fin_ff && !pull_in) begin
        if (cnt_ff == delay_in) begin
          done_ff <= 1'b1;
          fin_ff <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff + 4'h1;
        end
      end
    end
  end
  assign done_out = done_ff;
  // Match means nothing away from done; a toggling value there exposes early sampling
  assign match_out = done_ff ? match_mode_in : tog_ff;
  assign present_out = !pull_in;
endmodule
`default_nettype wire

//--- test/media_card_transfer_commands_test.sv
// Self-checking bench of the card command decoder against an integer model
`timescale 1ns/100ps
`default_nettype none
module media_card_transfer_commands_test;
  import mct_pkg::*;
  logic clk, srst, drst, sd, done, mt_in, pres, mt, pull, req, boot, diff, nocp, wp, warn, trip;
  logic [3:0] op, dly, awaddr, araddr;
  logic [9:0] blk;
  logic [2:0] slot;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, r;
  logic [31:0] d;
  logic [15:0] lf;
  logic [3:0] strb;
  int n_mismatch, checks, m_cmd, m_wp, m_warn, m_trip, e_blk, e_slot, e_kind, i;
  mct_op_type e_op;
  int codes[19] = '{2001, 4000, 5999, 6001, 7000, 8020, 9999, 15001, 16002, 17003, 21004,
    18005, 19006, 20007, 22008, 40009, 60010, 9666, 9555};
  mct_cmd_decoder mct_cmd_decoder_i (.clock_in(clk), .srst_in(srst), .drive_reset_in(drst),
    .card_present_in(pres), .card_sd_in(sd), .card_done_in(done), .card_match_in(mt_in),
    .card_req_out(req), .card_op_out(op), .card_block_out(blk), .card_slot_out(slot),
    .card_boot_out(boot), .card_diff_only_out(diff), .card_skip_nocopy_out(nocp),
    .wp_flag_out(wp), .warn_flag_out(warn), .trip_out(trip), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(strb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready));
  mct_card_model mct_card_model_i (.clock_in(clk), .srst_in(srst), .req_in(req),
    .delay_in(dly), .match_mode_in(mt), .pull_in(pull), .done_out(done), .match_out(mt_in),
    .present_out(pres));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tmo();
    n_mismatch++;
    $display("mismatch wait expected answer seen none");
    report_and_stop();
  endtask
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v);
    int n;
    awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 50) tmo();
    r = bresp;
  endtask
  task automatic axi_rd(input logic [3:0] a);
    int n;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 50) tmo();
    r = rresp;
    d = rdata;
  endtask
  task automatic check_regs();
    axi_rd(REG_CMD);
    check("cmd", {16'h0, d[15:0]}, m_cmd);
    check("cmd resp", r, RESP_OKAY);
    axi_rd(REG_STATUS);
    check("status", d, (m_trip << 3) | (m_warn << 2) | (m_wp << 1));
    check("flags", {trip, warn, wp}, {m_trip != 0, m_warn[0], m_wp[0]});
  endtask
  task automatic decode(input int c, input bit s);
    int p;
    p = c / 1000;
    e_op = OP_NONE; e_slot = 0; e_blk = c % 1000; e_kind = 0;
    if (c == 2001) begin e_op = OP_PSAVE; e_blk = 1; end
    else if (c == 9999) begin e_op = OP_FORMAT; e_blk = 0; end
    else if (c inside {9555, 9666, 9777, 9888}) e_kind = 2;
    else if (e_blk >= 1) begin
      case (p)
        4: e_op = OP_PSAVE;
        5: e_op = OP_GSAVE;
        6: e_op = OP_LOAD;
        7: e_op = OP_ERASE;
        8: e_op = OP_CMP;
        15, 16, 17, 21: begin e_op = OP_OSAVE; e_slot = p == 21 ? 4 : p - 14; end
        18, 19, 20, 22: begin e_op = OP_OLOAD; e_slot = p == 22 ? 4 : p - 17; end
        40: e_op = OP_BACKUP;
        60: e_op = OP_RESTORE;
        default: e_op = OP_NONE;
      endcase
    end
    if (!s && e_op inside {OP_OSAVE, OP_OLOAD, OP_BACKUP, OP_RESTORE}) e_op = OP_NONE;
    if (e_op != OP_NONE) e_kind = 1;
    if (m_wp != 0 && e_op != OP_LOAD && c != 9777)
      e_kind = e_op inside {OP_PSAVE, OP_GSAVE, OP_ERASE, OP_FORMAT, OP_OSAVE, OP_BACKUP} ? 3 : 0;
  endtask
  task automatic run_cmd(input int c, input bit s, input bit m, input int dl, input int pl);
    int n;
    decode(c, s);
    m_cmd = c;
    axi_wr(REG_CMD, c);
    sd <= s; mt <= m; dly <= dl[3:0]; drst <= 1'b1;
    @(posedge clk);
    drst <= 1'b0;
    @(posedge clk);
    check("req", req, e_kind == 1);
    if (e_kind == 1) begin
      check("op", op, e_op);
      check("blk", blk, e_blk);
      check("slot", slot, e_slot);
      check("boot", boot, c == 2001);
      check("diff", diff, c / 1000 == 4);
      check("nocopy", nocp,
        e_op inside {OP_PSAVE, OP_GSAVE, OP_ERASE, OP_FORMAT, OP_OSAVE, OP_BACKUP});
      if (pl > 0) begin
        repeat (pl) @(posedge clk);
        pull <= 1'b1;
      end
      for (n = 0; n < 60 && req; n++) @(posedge clk);
      if (n == 60) tmo();
      pull <= 1'b0;
      if (pl > 0) m_trip |= 4;
      else if (e_op == OP_CMP && !m) m_trip |= 1;
      else m_cmd = 0;
    end else if (e_kind == 2) begin
      if (c == 9666 || c == 9555) m_warn = c == 9666;
      else m_wp = c == 9888;
      m_cmd = 0;
    end else if (e_kind == 3) m_trip |= 2;
    check_regs();
  endtask
  initial begin
    {srst, drst, sd, mt, pull, awvalid, wvalid, bready, arvalid, rready} = 10'h200;
    dly = 4'h0; awaddr = 4'h0; araddr = 4'h0; wdata = 32'h0;
    strb = 4'hf;
    {m_cmd, m_wp, m_warn, m_trip} = '0;
    lf = 16'h0025;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    check_regs();
    axi_rd(4'hc);
    check("unmapped rd", d, 32'h0);
    check("unmapped rd resp", 32'(r), 32'(RESP_SLVERR));
    axi_wr(4'hc, 32'h1234);
    check("unmapped wr", r, RESP_SLVERR);
    axi_wr(REG_STATUS, 32'h3f);
    check("status wr", r, RESP_OKAY);
    check_regs();
    // Byte strobes build a valid code that must still wait for a drive reset
    strb <= 4'h1;
    axi_wr(REG_CMD, 32'h0000_0fa5);
    strb <= 4'h2;
    axi_wr(REG_CMD, 32'h0000_17ff);
    strb <= 4'hf;
    m_cmd = 'h17a5;
    repeat (3) @(posedge clk);
    check("req no drive reset", req, 0);
    check_regs();
    $display("test registers done");
    for (i = 0; i < 19; i++) begin
      lf = lfsr_next(lf);
      run_cmd(codes[i] + (codes[i] % 1000 == 0 ? lf % 999 + 1 : 0), 1, 1, i % 2 ? 0 : 7, 0);
    end
    $display("test code table done");
    run_cmd(4000, 1, 1, 0, 0);
    run_cmd(3005, 1, 1, 0, 0);
    run_cmd(15001, 0, 1, 0, 0);
    run_cmd(40009, 0, 1, 0, 0);
    run_cmd(8003, 1, 0, 2, 0);
    $display("test refusals done");
    foreach (codes[j]) if (j < 4) run_cmd(j == 0 ? 9888 : 3999 + j * 1001, 1, 1, 1, 0);
    run_cmd(9999, 1, 1, 0, 0);
    run_cmd(9666, 1, 1, 0, 0);
    run_cmd(6002, 1, 1, 0, 0);
    run_cmd(9777, 1, 1, 0, 0);
    run_cmd(4006, 1, 1, 0, 0);
    $display("test write protect done");
    run_cmd(7003, 1, 1, 15, 3);
    axi_wr(REG_TRIP_CLR, 32'h38);
    m_trip = 0;
    check_regs();
    $display("test removal and trip clear done");
    report_and_stop();
  end
endmodule
`default_nettype wire
